// file: pkg/hci_uart_params.svh
`ifndef HCI_UART_PARAMS_SVH
`define HCI_UART_PARAMS_SVH
// Clock and baud figures
`define CLK_HZ           125000000
`define BAUD_DEFAULT     115200
`define BAUD_MAX         1500000
// Divider for the reset-time rate, cycles per bit
`define DIV_DEFAULT      (`CLK_HZ / `BAUD_DEFAULT)
// Least divider that still meets the top rate
`define DIV_MIN          (`CLK_HZ / `BAUD_MAX)
`define DIV_WIDTH        16
// FIFO depth in bytes
`define FIFO_DEPTH       1040
// Free-entry margin at which the receiver raises its hold-off
`define FIFO_MARGIN      16
// Character layout: data bits per character
`define DATA_BITS        8
// H4 packet type indicators
`define H4_COMMAND       8'h01
`define H4_ACL           8'h02
`define H4_SCO           8'h03
`define H4_EVENT         8'h04
`endif

// file: pkg/hci_uart_pkg.sv
`default_nettype none
package hci_uart_pkg;
    // Serialiser and deserialiser states
    typedef enum logic [1:0] {
        LINE_IDLE  = 2'b00,
        LINE_START = 2'b01,
        LINE_DATA  = 2'b10,
        LINE_STOP  = 2'b11
    } line_state_t;
endpackage
`default_nettype wire

// file: pkg/hci_uart_if.sv
`timescale 1ns/1ps
`default_nettype none
// Four-wire link plus wake line; flow lines are active low (low = may send)
interface hci_uart_if;
    logic hostToDev;     // Host transmit, device receive
    logic devToHost;     // Device transmit, host receive
    logic devRtsN;       // Device hold-off toward host, high = stop
    logic hostRtsN;      // Host hold-off toward device, high = stop
    logic hostWake;      // Device wake request toward host
    modport device (input hostToDev, output devToHost, output devRtsN,
                    input hostRtsN, output hostWake);
    modport host (output hostToDev, input devToHost, input devRtsN,
                  output hostRtsN, input hostWake);
endinterface
`default_nettype wire

// file: core/hci_uart_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "hci_uart_params.svh"
// Functional notes
// [RQ1] Four wires: receive, transmit, RTS, CTS
// [RQ2] Programmable baud from 115200 to 1.5M
// [RQ3] Baud changes on host vendor command
// [RQ4] Combined baud error within five percent
// [RQ5] 1040-byte receive and transmit FIFOs
// [RQ6] H4 transport framing on link
// [RQ7] Reset rate is 115.2 kbaud
// [RQ8] Wake output asks host to wake
// [RQ9] Wake inactive until host enables it
// [RQ10] Same UART for programming and HCI
// [RQ11] Host without flow control holds CTS low
// [RQ12] RTS may float during firmware upload
// [RQ13] 8N1 framing, least significant bit first
// [RQ14] Active-low flow control, RTS near full
////////////////////////////////////////////////////////////////////////////////
// Shared UART engine: FIFO-buffered transmitter and receiver, one clock.
// Used unchanged by both ends so each keeps the same character rules.
module hci_uart_engine #(
    parameter int DEPTH  = `FIFO_DEPTH,           // FIFO depth in bytes
    parameter int MARGIN = `FIFO_MARGIN           // Free entries for hold-off
) (
    input  wire logic                  clk,       // System clock
    input  wire logic                  rst,       // Async reset, high
    input  wire logic [`DIV_WIDTH-1:0] div,       // Cycles per bit
    input  wire logic [7:0]            txData,    // Byte to send
    input  wire logic                  txValid,   // Byte offered
    output logic                       txReady,   // Byte accepted
    output logic [7:0]                 rxData,    // Byte received
    output logic                       rxValid,   // Byte offered to user
    input  wire logic                  rxReady,   // User takes byte
    output logic                       rxFramingError, // Bad stop bit pulse
    output logic                       rxOverflow,     // Byte lost pulse
    input  wire logic                  serialIn,  // Line from far end
    output logic                       serialOut, // Line to far end
    input  wire logic                  ctsN,      // Far end hold-off, low = go
    output logic                       rtsN       // Own hold-off, high = stop
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap, used by both FIFOs
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO
    logic [7:0]  txMem [DEPTH];
    logic [AW-1:0] txWr, txRd;
    logic [AW:0]   txCount;
    logic          txPop;
    assign txReady = (txCount != (AW+1)'(DEPTH)); // RQ5
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            txWr <= '0;
            txRd <= '0;
            txCount <= '0;
        end
        else
        begin
            if (txValid && txReady)
                txWr <= bump(txWr);
            if (txPop)
                txRd <= bump(txRd);
            txCount <= txCount + (AW+1)'(txValid && txReady) - (AW+1)'(txPop);
        end
    always_ff @(posedge clk)
        if (txValid && txReady)
            txMem[txWr] <= txData;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; first stages feed only second stages
    logic rxMeta, rxSync, ctsMeta, ctsSync;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
            ctsMeta <= 1'b1;
            ctsSync <= 1'b1;
        end
        else
        begin
            rxMeta <= serialIn;
            rxSync <= rxMeta;
            ctsMeta <= ctsN;
            ctsSync <= ctsMeta;
        end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: start only on an idle line while CTS is low
    hci_uart_pkg::line_state_t txState;
    logic [`DIV_WIDTH-1:0] txTick;
    logic [2:0]            txBit;
    logic [7:0]            txShift;
    assign txPop = (txState == hci_uart_pkg::LINE_IDLE) && (txCount != '0)
                   && !ctsSync; // RQ14
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            txState <= hci_uart_pkg::LINE_IDLE;
            txTick <= '0;
            txBit <= '0;
            txShift <= '0;
            serialOut <= 1'b1;
        end
        else
        begin
            if (txTick != '0)
                txTick <= txTick - 1'b1;
            case (txState)
                hci_uart_pkg::LINE_IDLE:
                begin
                    serialOut <= 1'b1;
                    if (txPop)
                    begin
                        txShift <= txMem[txRd];
                        serialOut <= 1'b0; // RQ13
                        txTick <= div - 1'b1;
                        txState <= hci_uart_pkg::LINE_START;
                    end
                end
                hci_uart_pkg::LINE_START:
                    if (txTick == '0)
                    begin
                        serialOut <= txShift[0]; // RQ13
                        txShift <= {1'b0, txShift[7:1]};
                        txBit <= '0;
                        txTick <= div - 1'b1;
                        txState <= hci_uart_pkg::LINE_DATA;
                    end
                hci_uart_pkg::LINE_DATA:
                    if (txTick == '0)
                    begin
                        txTick <= div - 1'b1;
                        if (txBit == 3'd7)
                        begin
                            serialOut <= 1'b1; // RQ13
                            txState <= hci_uart_pkg::LINE_STOP;
                        end
                        else
                        begin
                            serialOut <= txShift[0];
                            txShift <= {1'b0, txShift[7:1]};
                            txBit <= txBit + 3'd1;
                        end
                    end
                hci_uart_pkg::LINE_STOP:
                    if (txTick == '0)
                        txState <= hci_uart_pkg::LINE_IDLE;
                default:
                    txState <= hci_uart_pkg::LINE_IDLE;
            endcase
        end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: sample mid-bit, which tolerates the combined rate error
    hci_uart_pkg::line_state_t rxState;
    logic [`DIV_WIDTH-1:0] rxTick;
    logic [2:0]            rxBit;
    logic [7:0]            rxShift;
    logic                  rxPush;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            rxState <= hci_uart_pkg::LINE_IDLE;
            rxTick <= '0;
            rxBit <= '0;
            rxShift <= '0;
            rxPush <= 1'b0;
            rxFramingError <= 1'b0;
        end
        else
        begin
            rxPush <= 1'b0;
            rxFramingError <= 1'b0;
            if (rxTick != '0)
                rxTick <= rxTick - 1'b1;
            case (rxState)
                hci_uart_pkg::LINE_IDLE:
                    if (!rxSync)
                    begin
                        rxTick <= {1'b0, div[`DIV_WIDTH-1:1]}; // RQ4
                        rxState <= hci_uart_pkg::LINE_START;
                    end
                hci_uart_pkg::LINE_START:
                    if (rxTick == '0)
                    begin
                        // Glitch shorter than half a bit is dropped
                        rxState <= rxSync ? hci_uart_pkg::LINE_IDLE
                                          : hci_uart_pkg::LINE_DATA;
                        rxTick <= div - 1'b1;
                        rxBit <= '0;
                    end
                hci_uart_pkg::LINE_DATA:
                    if (rxTick == '0)
                    begin
                        rxShift <= {rxSync, rxShift[7:1]}; // RQ13
                        rxTick <= div - 1'b1;
                        rxBit <= rxBit + 3'd1;
                        if (rxBit == 3'd7)
                            rxState <= hci_uart_pkg::LINE_STOP;
                    end
                hci_uart_pkg::LINE_STOP:
                    if (rxTick == '0)
                    begin
                        rxPush <= rxSync;
                        rxFramingError <= !rxSync;
                        rxState <= hci_uart_pkg::LINE_IDLE;
                    end
                default:
                    rxState <= hci_uart_pkg::LINE_IDLE;
            endcase
        end

    ////////////////////////////////////////////////////////////////////////////
    // Receive FIFO with hold-off when few entries remain free
    logic [7:0]    rxMem [DEPTH];
    logic [AW-1:0] rxWr, rxRd;
    logic [AW:0]   rxCount;
    logic          rxFull, rxTake;
    assign rxFull = (rxCount == (AW+1)'(DEPTH));
    assign rxTake = rxValid && rxReady;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            rxWr <= '0;
            rxRd <= '0;
            rxCount <= '0;
            rxOverflow <= 1'b0;
            rtsN <= 1'b0;
        end
        else
        begin
            rxOverflow <= rxPush && rxFull;
            if (rxPush && !rxFull)
                rxWr <= bump(rxWr);
            if (rxTake)
                rxRd <= bump(rxRd);
            rxCount <= rxCount + (AW+1)'(rxPush && !rxFull) - (AW+1)'(rxTake);
            rtsN <= (rxCount >= (AW+1)'(DEPTH - MARGIN)); // RQ14
        end
    always_ff @(posedge clk)
        if (rxPush && !rxFull)
            rxMem[rxWr] <= rxShift; // RQ5
    assign rxValid = (rxCount != '0);
    assign rxData  = rxMem[rxRd];
endmodule // hci_uart_engine
`default_nettype wire

// file: core/hci_uart_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "hci_uart_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Module-side end: rate control, wake line and the shared engine.
module hci_uart_device #(
    parameter int DEPTH = `FIFO_DEPTH            // FIFO depth in bytes
) (
    input  wire logic                  clk,        // System clock
    input  wire logic                  rst,        // Async reset, high
    hci_uart_if.device                 link,       // Pins toward host
    input  wire logic [`DIV_WIDTH-1:0] newDiv,     // Rate from vendor command
    input  wire logic                  setDiv,     // Apply newDiv, pulse
    input  wire logic                  wakeEnable, // Set by vendor command
    input  wire logic                  wakeNeed,   // Controller wants host
    input  wire logic [7:0]            txData,     // Event/data byte
    input  wire logic                  txValid,    // Byte offered
    output logic                       txReady,    // Byte accepted
    output logic [7:0]                 rxData,     // Command/data byte
    output logic                       rxValid,    // Byte available
    input  wire logic                  rxReady,    // Byte taken
    output logic                       rxFramingError, // Bad stop, pulse
    output logic                       rxOverflow  // Byte lost, pulse
);
    logic [`DIV_WIDTH-1:0] div;
    // Reset rate 115.2k; out-of-range requests are ignored
    always_ff @(posedge clk or posedge rst)
        if (rst)
            div <= `DIV_WIDTH'(`DIV_DEFAULT); // RQ7
        else if (setDiv && newDiv >= `DIV_WIDTH'(`DIV_MIN)
                 && newDiv <= `DIV_WIDTH'(`DIV_DEFAULT))
            div <= newDiv; // RQ2 RQ3

    // Wake stays low until enabled
    always_ff @(posedge clk or posedge rst)
        if (rst)
            link.hostWake <= 1'b0;
        else
            link.hostWake <= wakeEnable && wakeNeed; // RQ8 RQ9

    // One engine serves programming and HCI traffic alike
    hci_uart_engine #(.DEPTH(DEPTH)) engine ( // RQ10 RQ1
        .clk            (clk),
        .rst            (rst),
        .div            (div),
        .txData         (txData),
        .txValid        (txValid),
        .txReady        (txReady),
        .rxData         (rxData),
        .rxValid        (rxValid),
        .rxReady        (rxReady),
        .rxFramingError (rxFramingError),
        .rxOverflow     (rxOverflow),
        .serialIn       (link.hostToDev),
        .serialOut      (link.devToHost),
        .ctsN           (link.hostRtsN),
        .rtsN           (link.devRtsN)
    );
endmodule // hci_uart_device
`default_nettype wire

// file: core/hci_uart_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "hci_uart_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Host-side end: same engine, optional flow control, wake observed.
module hci_uart_host #(
    parameter int DEPTH = `FIFO_DEPTH            // FIFO depth in bytes
) (
    input  wire logic                  clk,        // System clock
    input  wire logic                  rst,        // Async reset, high
    hci_uart_if.host                   link,       // Pins toward device
    input  wire logic [`DIV_WIDTH-1:0] newDiv,     // Rate after change command
    input  wire logic                  setDiv,     // Apply newDiv, pulse
    input  wire logic                  flowOn,     // Use hardware flow control
    input  wire logic [7:0]            txData,     // Command byte
    input  wire logic                  txValid,    // Byte offered
    output logic                       txReady,    // Byte accepted
    output logic [7:0]                 rxData,     // Event byte
    output logic                       rxValid,    // Byte available
    input  wire logic                  rxReady,    // Byte taken
    output logic                       rxFramingError, // Bad stop, pulse
    output logic                       rxOverflow, // Byte lost, pulse
    output logic                       wakeSeen    // Synchronised wake level
);
    logic [`DIV_WIDTH-1:0] div;
    logic                  ownRtsN, wakeMeta;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            div <= `DIV_WIDTH'(`DIV_DEFAULT);
        else if (setDiv)
            div <= newDiv; // RQ3

    // Without flow control the hold-off line is held low
    assign link.hostRtsN = flowOn ? ownRtsN : 1'b0; // RQ11

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            wakeMeta <= 1'b0;
            wakeSeen <= 1'b0;
        end
        else
        begin
            wakeMeta <= link.hostWake;
            wakeSeen <= wakeMeta;
        end

    // Device RTS honoured only with flow control on
    hci_uart_engine #(.DEPTH(DEPTH)) engine ( // RQ12 RQ6
        .clk            (clk),
        .rst            (rst),
        .div            (div),
        .txData         (txData),
        .txValid        (txValid),
        .txReady        (txReady),
        .rxData         (rxData),
        .rxValid        (rxValid),
        .rxReady        (rxReady),
        .rxFramingError (rxFramingError),
        .rxOverflow     (rxOverflow),
        .serialIn       (link.devToHost),
        .serialOut      (link.hostToDev),
        .ctsN           (flowOn ? link.devRtsN : 1'b0),
        .rtsN           (ownRtsN)
    );
endmodule // hci_uart_host
`default_nettype wire

// file: testbench/hci_uart_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "hci_uart_params.svh"
////////////////////////////////////////////////////////////////
// Pin-level checks on the link between the two ends
module hci_uart_link_sva (
    input wire logic clk,       // Clock
    input wire logic rst,       // Reset, high
    input wire logic hostToDev, // Host line
    input wire logic devToHost, // Device line
    input wire logic devRtsN,   // Device hold-off
    input wire logic hostRtsN,  // Host hold-off
    input wire logic hostWake   // Wake line
);
    localparam int DIV_LO = `DIV_MIN;
    localparam int RUN_HI = 9 * `DIV_DEFAULT;
    // One slow frame plus one bit of slack, since a frame in flight may finish
    localparam int HOLD = 11 * `DIV_DEFAULT;
    logic [15:0] lowD;
    logic [15:0] lowH;
    logic [15:0] holdD;
    logic [15:0] holdH;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Low-run and hold-off counters; only the hold-off counters saturate, the low-run ones can wrap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lowD  <= 16'h0000;
            lowH  <= 16'h0000;
            holdD <= 16'h0000;
            holdH <= 16'h0000;
        end
        else
        begin
            lowD  <= devToHost ? 16'h0000 : lowD + 16'h0001;
            lowH  <= hostToDev ? 16'h0000 : lowH + 16'h0001;
            holdD <= !devRtsN ? 16'h0000 : (&holdD ? holdD : holdD + 16'h0001);
            holdH <= !hostRtsN ? 16'h0000 : (&holdH ? holdH : holdH + 16'h0001);
        end
    end
    a_reset_idle: assert property ($past(rst) |-> devToHost && hostToDev && !hostWake)
        else $error("lines not idle after reset");
    a_reset_ready: assert property ($past(rst) |-> !devRtsN && !hostRtsN)
        else $error("hold-off raised after reset");
    a_bit_min_dev: assert property ($rose(devToHost) |-> lowD >= DIV_LO)
        else $error("device low pulse shorter than a bit");
    a_bit_min_host: assert property ($rose(hostToDev) |-> lowH >= DIV_LO)
        else $error("host low pulse shorter than a bit");
    a_stop_dev: assert property (lowD <= RUN_HI)
        else $error("device line low past a frame");
    a_stop_host: assert property (lowH <= RUN_HI)
        else $error("host line low past a frame");
    a_hold_host: assert property (holdD > HOLD |-> !$fell(hostToDev))
        else $error("host sent while held off");
    a_hold_dev: assert property (holdH > HOLD |-> !$fell(devToHost))
        else $error("device sent while held off");
    c_dev_hold: cover property ($rose(devRtsN));
    c_host_hold: cover property (holdH > HOLD);
    c_wake: cover property ($rose(hostWake));
endmodule // hci_uart_link_sva
`default_nettype wire

// file: testbench/hci_uart_host_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hci_uart_params.svh"
module hci_uart_host_link_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] newDiv = 16'h0000;
    logic        setDiv = 1'b0, flowOn = 1'b1, wakeEnable = 1'b0, wakeNeed = 1'b0;
    logic        stallD = 1'b0, stallH = 1'b0;
    logic [7:0]  dTxData = 8'h00, hTxData = 8'h00, dRxData, hRxData;
    logic        dTxValid = 1'b0, hTxValid = 1'b0, dRxReady = 1'b0, hRxReady = 1'b0;
    logic        dTxReady, hTxReady, dRxValid, hRxValid, dFe, hFe, dOv, hOv, wakeSeen;
    logic [7:0]  toDev[$], toHost[$];
    int          nFail = 0, checks = 0, seed = 32'hABA4;
    hci_uart_if link ();
    hci_uart_device #(.DEPTH(32)) i_hci_uart_device (.clk(clk), .rst(rst), .link(link),
        .newDiv(newDiv), .setDiv(setDiv), .wakeEnable(wakeEnable), .wakeNeed(wakeNeed),
        .txData(dTxData), .txValid(dTxValid), .txReady(dTxReady), .rxData(dRxData),
        .rxValid(dRxValid), .rxReady(dRxReady), .rxFramingError(dFe), .rxOverflow(dOv));
    hci_uart_host #(.DEPTH(32)) i_hci_uart_host (.clk(clk), .rst(rst), .link(link),
        .newDiv(newDiv), .setDiv(setDiv), .flowOn(flowOn), .txData(hTxData),
        .txValid(hTxValid), .txReady(hTxReady), .rxData(hRxData), .rxValid(hRxValid),
        .rxReady(hRxReady), .rxFramingError(hFe), .rxOverflow(hOv), .wakeSeen(wakeSeen));
    hci_uart_link_sva i_hci_uart_link_sva (.clk(clk), .rst(rst), .hostToDev(link.hostToDev),
        .devToHost(link.devToHost), .devRtsN(link.devRtsN), .hostRtsN(link.hostRtsN),
        .hostWake(link.hostWake));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            nFail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Valid stays up between bytes; the caller lowers it after a burst
    task automatic send(input bit fromHost, input logic [7:0] b);
        int n;
        n = 0;
        if (fromHost)
        begin
            hTxData = b;
            hTxValid = 1'b1;
        end
        else
        begin
            dTxData = b;
            dTxValid = 1'b1;
        end
        while ((fromHost ? hTxReady : dTxReady) !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 50000)
            begin
                nFail++;
                results();
            end
        end
        @(negedge clk);
        if (fromHost)
            toDev.push_back(b);
        else
            toHost.push_back(b);
    endtask
    task automatic burst(input bit fromHost, input int n, input logic [7:0] first);
        send(fromHost, first);
        for (int i = 1; i < n; i++)
            send(fromHost, 8'($random(seed)));
        if (fromHost)
            hTxValid = 1'b0;
        else
            dTxValid = 1'b0;
    endtask
    task automatic rate(input logic [15:0] d);
        newDiv = d;
        setDiv = 1'b1;
        @(negedge clk);
        setDiv = 1'b0;
    endtask
    // Expected line image: eight data bits, then a high stop bit in bit 0
    function automatic logic [15:0] frame_of(input logic [7:0] b);
        return {b, 8'h01};
    endfunction
    // Times the start bit and samples each bit mid-way; bit 0 forced high
    task automatic wire_check(input logic [15:0] d);
        logic [7:0] b, got;
        int n;
        b = 8'($random(seed)) | 8'h01;
        send(1'b0, b);
        dTxValid = 1'b0;
        n = 0;
        while (link.devToHost !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (link.devToHost === 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check(16'(n), d);
        repeat (d / 2) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            got[i] = link.devToHost;
            repeat (d) @(negedge clk);
        end
        check({got, 7'h00, link.devToHost}, frame_of(b));
        repeat (d) @(negedge clk);
    endtask
    task automatic drain;
        int n;
        n = 0;
        while ((toDev.size() + toHost.size()) != 0 && n < 60000)
        begin
            @(negedge clk);
            n++;
        end
        check(16'(toDev.size() + toHost.size()), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    // Both receivers: draw the ready for the coming edge first, so the
    // compare pairs it with the head that this same edge will take
    always @(negedge clk)
    begin
        dRxReady = stallD ? 1'b0 : 1'($random(seed));
        hRxReady = stallH ? 1'b0 : 1'($random(seed));
        if (dRxValid === 1'b1 && dRxReady === 1'b1)
            check(16'(dRxData), 16'(toDev.size() ? toDev.pop_front() : 8'hXX));
        if (hRxValid === 1'b1 && hRxReady === 1'b1)
            check(16'(hRxData), 16'(toHost.size() ? toHost.pop_front() : 8'hXX));
        if ({dOv, dFe, hOv, hFe} !== 4'h0)
            check(16'({dOv, dFe, hOv, hFe}), 16'h0000);
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        wakeNeed = 1'b1;
        repeat (5) @(negedge clk);
        check(16'(link.hostWake), 16'h0000);
        wakeEnable = 1'b1;
        repeat (5) @(negedge clk);
        check(16'(wakeSeen), 16'h0001);
        wakeNeed = 1'b0;
        repeat (5) @(negedge clk);
        check(16'(wakeSeen), 16'h0000);
        $display("test wake done");
        wire_check(16'(`DIV_DEFAULT));
        rate(16'h0087);
        wire_check(16'h0087);
        rate(16'(`DIV_MIN));
        wire_check(16'(`DIV_MIN));
        $display("test rates done");
        fork
            burst(1'b1, 12, `H4_COMMAND);
            burst(1'b0, 12, `H4_EVENT);
        join
        drain();
        $display("test traffic done");
        // Both receivers stalled: each hold-off must stop the far sender
        stallD <= 1'b1;
        stallH <= 1'b1;
        fork
            burst(1'b1, 24, 8'h5A);
            burst(1'b0, 24, 8'hA5);
        join
        repeat (28000) @(negedge clk);
        check(16'({link.devRtsN, link.hostRtsN}), 16'h0003);
        for (int i = 0; i < 40 && hTxReady === 1'b1; i++)
            send(1'b1, 8'($random(seed)));
        check(16'(hTxReady), 16'h0000);
        hTxValid = 1'b0;
        stallD <= 1'b0;
        repeat (100) @(negedge clk);
        flowOn = 1'b0;
        repeat (3) @(negedge clk);
        check(16'(link.hostRtsN), 16'h0000);
        repeat (6000) @(negedge clk);
        flowOn = 1'b1;
        stallH <= 1'b0;
        drain();
        $display("test stall done");
        results();
    end
endmodule // hci_uart_host_link_tb
`default_nettype wire
